// File: hdl/vr_start_fault_sequencer.sv
// Start-up, power-good and fault supervisor of a multiphase regulator controller.
// What this block does
// - In shutdown every phase drive output is held high-impedance unless an overvoltage forces it low.
// - Soft-start begins when supply, rail gate, logic gate are good and code not all-ones.
// - All-ones code shuts down; any later other code restarts soft-start.
// - After all-ones code wait two cycles, then shutdown trip level and drive off.
// - The all-ones code and code changes never clear a latched overvoltage.
// - Soft-start waits 64 switching cycles, then ramps reference one step per 32 us.
// - During soft-start drive stays high-impedance until reference reaches pre-bias level.
// - Sense offset starts at 100 mV and ramps to zero over 640 cycles.
// - Power-good is low in shutdown and released after successful soft-start.
// - Power-good drops only on undervoltage or disable; returns after undervoltage.
// - Undervoltage below 75 percent of the code pulls power-good low.
// - Overvoltage alone never pulls power-good low.
// - With supply above 1.4 V but not valid, sense above 1.8 V trips overvoltage.
// - Overvoltage trip level is chosen by state: 1.7 V, max, or code plus 200 mV.
// - Overvoltage forces drive low within 20 ns until sense falls below release level.
// - Drive goes high-impedance at reference level and low again on each recurrence.
// - Crowbar output rises together with the forced-low drive.
// - After overvoltage switching stays stopped until a gate input or supply cycles.
// - Average phase current above the reference shuts the converter down.
// - Any phase above the reference for eight switching cycles shuts it down.
// - Overcurrent: high-impedance at once, wait 4096 cycles, retry while enabled.
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "vr_seq_cfg.svh"
module vr_start_fault_sequencer #(
  parameter int PHASES   = 4,
  parameter int SW_DIV   = `SW_DIV_DEF,
  parameter int STEP_CYC = `STEP_CYC
)(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [31:0]       rdata,
  input  wire logic              supply_valid,
  input  wire logic              supply_aux,
  input  wire logic              rail_gate_ok,
  input  wire logic              logic_level_gate,
  input  wire logic [5:0]        voltage_code,
  input  wire logic              ov_aux_trip,
  input  wire logic              ov_1v7_trip,
  input  wire logic              ov_1v5_trip,
  input  wire logic              ov_code_trip,
  input  wire logic              sense_below_0v6,
  input  wire logic              sense_below_1v5,
  input  wire logic              diff_at_ref,
  input  wire logic              uv_trip,
  input  wire logic              prebias_reached,
  input  wire logic              average_phase_current_over,
  input  wire logic [PHASES-1:0] phase_oc,
  output logic                   phase_hiz,
  output logic                   phase_force_low,
  output logic                   crowbar_drive,
  output logic                   power_good_out_o,
  output logic                   power_good_out_oe,
  output logic      [6:0]        ref_level,
  output logic      [3:0]        sense_offset,
  output logic      [1:0]        ov_level
);
  localparam int SW = 20 + PHASES;

  vr_seq_pkg::state_type state;
  vr_seq_pkg::state_type next_state;
  logic [SW-1:0] clean;
  logic [15:0]   sw_cnt;
  logic [15:0]   step_cnt;
  logic [12:0]   tick_cnt;
  logic [6:0]    ofs_cnt;
  logic [6:0]    next_ref;
  logic [3:0]    next_ofs;
  logic          ov_low;
  logic          ov_latched;
  logic          pg_flag;
  logic          prebias_seen;
  logic          noload_drive;
  logic          ocp_phase_en;
  logic [3:0]    ph_cnt [PHASES];
  logic [PHASES-1:0] ph_hit;

  // Every pin and comparator result goes through the same synchroniser.
  pin_sync #(
    .W(SW)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   ({phase_oc, voltage_code, supply_valid, supply_aux, rail_gate_ok,
             logic_level_gate, ov_aux_trip, ov_1v7_trip, ov_1v5_trip, ov_code_trip,
             sense_below_0v6, sense_below_1v5, diff_at_ref, uv_trip, prebias_reached,
             average_phase_current_over}),
    .dout  (clean)
  );

  wire [PHASES-1:0] s_phase = clean[SW-1:20];
  wire [5:0] s_code   = clean[19:14];
  wire s_valid        = clean[13];
  wire s_aux          = clean[12];
  wire s_rail         = clean[11];
  wire s_logic        = clean[10];
  wire s_ov_aux       = clean[9];
  wire s_ov_1v7       = clean[8];
  wire s_ov_1v5       = clean[7];
  wire s_ov_code      = clean[6];
  wire s_below_0v6    = clean[5];
  wire s_below_1v5    = clean[4];
  wire s_diff_ref     = clean[3];
  wire s_uv           = clean[2];
  wire s_prebias      = clean[1];
  wire s_avg_oc       = clean[0];

  wire sw_tick   = (sw_cnt == 16'(SW_DIV - 1));
  wire step_tick = (step_cnt == 16'(STEP_CYC - 1));
  wire [6:0] target = `DAC_BASE + {1'b0, s_code};

  // Gate inputs and supply form the base enable; the code adds the no-load exit.
  wire base_en  = s_valid & s_rail & s_logic;
  wire code_off = (s_code == `CODE_OFF);
  wire en       = base_en & !code_off;
  wire active   = (state == vr_seq_pkg::ST_RAMP) || (state == vr_seq_pkg::ST_RUN);

  // Trip level follows the state; the max of two levels is exceeding both.
  assign ov_level = (state == vr_seq_pkg::ST_OFF) ? vr_seq_pkg::LVL_1V7 :
                    (state == vr_seq_pkg::ST_DELAY || state == vr_seq_pkg::ST_RAMP) ?
                    vr_seq_pkg::LVL_MAX : vr_seq_pkg::LVL_CODE;
  wire ov_hit = (ov_level == vr_seq_pkg::LVL_1V7) ? s_ov_1v7 :
                (ov_level == vr_seq_pkg::LVL_MAX) ? (s_ov_1v5 & s_ov_code) : s_ov_code;
  // Auxiliary monitor covers the window where supply is up but not yet valid.
  wire ov_event   = s_valid ? ov_hit : (s_aux & s_ov_aux);
  wire ov_release = s_valid ? (s_below_0v6 | s_diff_ref) : s_below_1v5;

  // One phase over the limit for eight ticks in a row trips, as does the average.
  generate
    for (genvar i = 0; i < PHASES; i++) begin : g_phase
      always_ff @(posedge mclk) begin
        if (!rst_n || !s_phase[i]) begin
          ph_cnt[i] <= 4'h0;
        end else if (sw_tick && ph_cnt[i] != `OC_PHASE_SW) begin
          ph_cnt[i] <= ph_cnt[i] + 4'h1;
        end
      end
      assign ph_hit[i] = (ph_cnt[i] == `OC_PHASE_SW);
    end
  endgenerate
  wire oc_trip = s_avg_oc | (ocp_phase_en & (|ph_hit));

  always_comb begin
    next_state = state;
    unique case (state)
      vr_seq_pkg::ST_OFF: begin
        if (en) next_state = vr_seq_pkg::ST_DELAY;
      end
      vr_seq_pkg::ST_DELAY: begin
        if (sw_tick && tick_cnt == 13'(`SS_DELAY_SW - 1)) next_state = vr_seq_pkg::ST_RAMP;
      end
      vr_seq_pkg::ST_RAMP: begin
        if (ref_level >= target) next_state = vr_seq_pkg::ST_RUN;
      end
      vr_seq_pkg::ST_RUN: begin
        next_state = vr_seq_pkg::ST_RUN;
      end
      vr_seq_pkg::ST_NOLOAD: begin
        if (sw_tick && tick_cnt == 13'(`NOLOAD_SW - 1)) next_state = vr_seq_pkg::ST_OFF;
      end
      vr_seq_pkg::ST_OCWAIT: begin
        if (sw_tick && tick_cnt == 13'(`OC_WAIT_SW - 1)) begin
          next_state = en ? vr_seq_pkg::ST_DELAY : vr_seq_pkg::ST_OFF;
        end
      end
      vr_seq_pkg::ST_OVLAT: begin
        next_state = vr_seq_pkg::ST_OVLAT;
      end
      default: next_state = vr_seq_pkg::ST_OFF;
    endcase
    if (oc_trip && active) next_state = vr_seq_pkg::ST_OCWAIT;
    if (code_off && (active || state == vr_seq_pkg::ST_DELAY)) begin
      next_state = vr_seq_pkg::ST_NOLOAD;
    end
    if (ov_event && s_valid) next_state = vr_seq_pkg::ST_OVLAT;
    if (!base_en) next_state = vr_seq_pkg::ST_OFF;
  end

  always_comb begin
    unique case (state)
      vr_seq_pkg::ST_RAMP: next_ref = (step_tick && ref_level < target) ?
                                      ref_level + 7'h1 : ref_level;
      vr_seq_pkg::ST_RUN, vr_seq_pkg::ST_NOLOAD, vr_seq_pkg::ST_OVLAT: next_ref = target;
      default: next_ref = 7'h0;
    endcase
  end

  // The offset holds through the delay, then drops one step per 80 ticks.
  always_comb begin
    if (state == vr_seq_pkg::ST_DELAY) begin
      next_ofs = `OFS_STEPS;
    end else if (active) begin
      next_ofs = (sw_tick && ofs_cnt == 7'(`OFS_STEP_SW - 1) && sense_offset != 4'h0) ?
                 sense_offset - 4'h1 : sense_offset;
    end else begin
      next_ofs = 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= vr_seq_pkg::ST_OFF;
      tick_cnt <= 13'h0;
    end else begin
      state <= next_state;
      tick_cnt <= (next_state != state) ? 13'h0 : tick_cnt + 13'(sw_tick);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sw_cnt <= 16'h0;
      step_cnt <= 16'h0;
      ofs_cnt <= 7'h0;
      ref_level <= 7'h0;
      sense_offset <= 4'h0;
    end else begin
      sw_cnt <= sw_tick ? 16'h0 : sw_cnt + 16'h1;
      step_cnt <= (step_tick || state != vr_seq_pkg::ST_RAMP) ? 16'h0 : step_cnt + 16'h1;
      ofs_cnt <= (!active || (sw_tick && ofs_cnt == 7'(`OFS_STEP_SW - 1))) ? 7'h0 :
                 ofs_cnt + 7'(sw_tick);
      ref_level <= next_ref;
      sense_offset <= next_ofs;
    end
  end

  // A new trip wins over a release in the same cycle so no recurrence is lost.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ov_low <= 1'b0;
      ov_latched <= 1'b0;
      prebias_seen <= 1'b0;
    end else begin
      ov_low <= ov_event | (ov_low & !ov_release);
      ov_latched <= (ov_event & s_valid) | (ov_latched & base_en);
      prebias_seen <= (state == vr_seq_pkg::ST_RAMP) & (prebias_seen | s_prebias);
    end
  end

  // Overcurrent and overvoltage leave this flag alone; only disabling clears it.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pg_flag <= 1'b0;
    end else begin
      pg_flag <= (state == vr_seq_pkg::ST_RAMP && next_state == vr_seq_pkg::ST_RUN) |
                 (pg_flag & base_en & !code_off);
    end
  end

  // Drive state is decoded straight from flops to meet the short response time.
  wire running = (state == vr_seq_pkg::ST_RUN) ||
                 (state == vr_seq_pkg::ST_NOLOAD && noload_drive) ||
                 (state == vr_seq_pkg::ST_RAMP && prebias_seen);

  // A ramp cut by the no-load code before switching began must not switch for two ticks.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      noload_drive <= 1'b0;
    end else begin
      noload_drive <= (state == vr_seq_pkg::ST_NOLOAD) ? noload_drive : running;
    end
  end
  assign phase_force_low = ov_low;
  assign phase_hiz = !ov_low && !running;
  assign crowbar_drive = ov_low;
  assign power_good_out_o = 1'b0;
  assign power_good_out_oe = !(pg_flag && !s_uv);

  wire [31:0] stat_word = {17'h0, ref_level, pg_flag, s_uv, ov_low, ov_latched,
                           1'b0, state};
  wire [31:0] rd_next = (addr == `REG_CTRL) ? {31'h0, ocp_phase_en} :
                        (addr == `REG_STAT) ? stat_word : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ocp_phase_en <= `CTRL_RST;
      rdata <= 32'h0;
    end else begin
      if (wr_en && addr == `REG_CTRL) ocp_phase_en <= wdata[`CTRL_OCP_BIT];
      rdata <= rd_en ? rd_next : 32'h0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  localparam int RESP = `RESP_CYC;

  sequence ov_start_s;
    $rose(ov_event);
  endsequence
  sequence ov_drive_s;
    phase_force_low && crowbar_drive && !phase_hiz;
  endsequence

  shut_hiz_a:
    assert property (state == vr_seq_pkg::ST_OFF && !ov_low |-> phase_hiz && !phase_force_low)
    else $error("drive not high-impedance in shutdown");
  start_now_a:
    assert property (state == vr_seq_pkg::ST_OFF && en && !ov_event |=>
                     state == vr_seq_pkg::ST_DELAY)
    else $error("soft-start did not begin on enable");
  noload_enter_a:
    assert property (state == vr_seq_pkg::ST_RUN && code_off && base_en && !ov_event |=>
                     state == vr_seq_pkg::ST_NOLOAD)
    else $error("all-ones code did not shut down");
  noload_level_a:
    assert property (state == vr_seq_pkg::ST_NOLOAD && noload_drive |->
                     ov_level == vr_seq_pkg::LVL_CODE && !phase_hiz || ov_low)
    else $error("trip level or drive changed before the two-cycle wait");
  noload_hiz_a:
    assert property (state == vr_seq_pkg::ST_NOLOAD && !noload_drive && !ov_low |-> phase_hiz)
    else $error("drive switched while leaving an unfinished ramp");
  ov_latch_hold_a:
    assert property (state == vr_seq_pkg::ST_OVLAT && base_en |=>
                     state == vr_seq_pkg::ST_OVLAT && ov_latched)
    else $error("latched overvoltage was cleared while enabled");
  delay_len_a:
    assert property (state == vr_seq_pkg::ST_DELAY && next_state == vr_seq_pkg::ST_RAMP |->
                     tick_cnt == 13'(`SS_DELAY_SW - 1))
    else $error("soft-start delay not 64 switching cycles");
  prebias_hiz_a:
    assert property (state == vr_seq_pkg::ST_RAMP && !prebias_seen && !ov_low |-> phase_hiz)
    else $error("drive enabled below pre-bias level");
  ofs_start_a:
    assert property (state == vr_seq_pkg::ST_DELAY ##1 state == vr_seq_pkg::ST_RAMP |->
                     sense_offset == `OFS_STEPS)
    else $error("sense offset not full at ramp start");
  pg_shut_a:
    assert property (state == vr_seq_pkg::ST_OFF |=> power_good_out_oe)
    else $error("power-good released in shutdown");
  pg_uv_a:
    assert property (s_uv |-> power_good_out_oe)
    else $error("power-good high during undervoltage");
  pg_ov_a:
    assert property (ov_event && base_en && !code_off && pg_flag |=> pg_flag)
    else $error("overvoltage cleared power-good");
  ov_fast_a:
    assert property (ov_start_s |=> ov_drive_s)
    else $error("overvoltage drive not forced low with crowbar");
  oc_hiz_a:
    assert property (oc_trip && active && base_en && !code_off && !ov_event |=>
                     state == vr_seq_pkg::ST_OCWAIT && (phase_hiz || ov_low))
    else $error("overcurrent did not float the drive");
  phase_oc_a:
    assert property (ocp_phase_en && (|ph_hit) && active && base_en && !code_off &&
                     !ov_event |=> state == vr_seq_pkg::ST_OCWAIT)
    else $error("sustained phase overcurrent not acted on");
  sync_lat_a:
    assert property ($rose(uv_trip) ##1 uv_trip [*3] |-> ##[0:RESP] s_uv)
    else $error("synchronised input late");
endmodule

// File: hdl/vr_seq_cfg.svh
// Timing counts, offsets and reset values of the start-up and fault sequencer.
`ifndef VR_SEQ_CFG_SVH
`define VR_SEQ_CFG_SVH
`define MCLK_NS 5
`define SW_DIV_DEF 400
`define SS_DELAY_SW 64
`define STEP_US 32
`define STEP_CYC ((`STEP_US * 1000 + `MCLK_NS - 1) / `MCLK_NS)
`define OFS_STEPS 4'h8
`define OFS_RAMP_SW 640
`define OFS_STEP_SW (`OFS_RAMP_SW / 8)
`define NOLOAD_SW 2
`define OC_WAIT_SW 4096
`define OC_PHASE_SW 4'h8
`define RESP_NS 20
`define RESP_CYC (`RESP_NS / `MCLK_NS)
`define CODE_OFF 6'h3f
`define DAC_BASE 7'h2a
`define REG_CTRL 8'h00
`define REG_STAT 8'h04
`define CTRL_RST 1'h1
`define CTRL_OCP_BIT 0
`endif

// File: hdl/vr_seq_pkg.sv
// Types shared by the start-up and fault sequencer.
package vr_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_DELAY  = 3'h1,
    ST_RAMP   = 3'h2,
    ST_RUN    = 3'h3,
    ST_NOLOAD = 3'h4,
    ST_OCWAIT = 3'h5,
    ST_OVLAT  = 3'h6
  } state_type;
  typedef enum logic [1:0] {
    LVL_1V7  = 2'h0,
    LVL_MAX  = 2'h1,
    LVL_CODE = 2'h2
  } lvl_type;
endpackage

// File: hdl/pin_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 8
)(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] held;
  wire  [W-1:0] agree = ~(s2 ^ s3);

  // A bit that disagrees between stages keeps its last accepted value.
  assign dout = (agree & s2) | (~agree & held);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      held <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      held <= dout;
    end
  end
endmodule

// File: verification/vr_far_side.sv
// Behavioural model of the gate drivers and the power monitor at the sequencer's far side.
`timescale 1ns/10ps
module vr_far_side (
  input  wire logic       mclk,
  input  wire logic       phase_hiz,
  input  wire logic       phase_force_low,
  input  wire logic       power_good_out_o,
  input  wire logic       power_good_out_oe,
  output logic            power_good_level,
  output logic      [1:0] drive_mode,
  output logic            drive_clash
);
  // The power-good line has a pull-up, so a released line reads high.
  assign power_good_level = power_good_out_oe ? power_good_out_o : 1'b1;
  // Mode 0 is switching, 1 both devices off, 2 lower device on.
  assign drive_mode = phase_force_low ? 2'h2 : (phase_hiz ? 2'h1 : 2'h0);
  // A driver told to float and to pull low at once cannot obey both.
  always_ff @(posedge mclk) begin
    drive_clash <= phase_hiz & phase_force_low;
  end
endmodule

// File: verification/test_vr_start_fault_sequencer.sv
// Self-checking bench of the start-up and fault sequencer and its far side.
`timescale 1ns/10ps
module test_vr_start_fault_sequencer;
  logic        mclk, rst_n, wr_en, rd_en, pg_o, pg_oe, pg, clash;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic        sv, saux, rail, llg, ov_aux, ov17, ov15, ov_code, b06, b15, at_ref, uv, pre;
  logic        avg_oc, hiz, low, crow;
  logic [5:0]  code;
  logic [3:0]  ph_oc, ofs;
  logic [6:0]  ref_lvl, r0;
  logic [1:0]  ovl, mode;
  int          failures, checks, cyc;

  vr_start_fault_sequencer #(.PHASES(4), .SW_DIV(4), .STEP_CYC(8)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .supply_valid(sv), .supply_aux(saux), .rail_gate_ok(rail),
    .logic_level_gate(llg), .voltage_code(code), .ov_aux_trip(ov_aux), .ov_1v7_trip(ov17),
    .ov_1v5_trip(ov15), .ov_code_trip(ov_code), .sense_below_0v6(b06),
    .sense_below_1v5(b15), .diff_at_ref(at_ref), .uv_trip(uv), .prebias_reached(pre),
    .average_phase_current_over(avg_oc), .phase_oc(ph_oc), .phase_hiz(hiz),
    .phase_force_low(low), .crowbar_drive(crow), .power_good_out_o(pg_o),
    .power_good_out_oe(pg_oe), .ref_level(ref_lvl), .sense_offset(ofs), .ov_level(ovl));

  vr_far_side far_u (.mclk(mclk), .phase_hiz(hiz), .phase_force_low(low),
    .power_good_out_o(pg_o), .power_good_out_oe(pg_oe), .power_good_level(pg),
    .drive_mode(mode), .drive_clash(clash));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_st(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    rd(8'h04, v);
    while (v[2:0] !== s && n < lim) begin
      rd(8'h04, v);
      n++;
    end
    check(v[2:0], s, "state");
  endtask

  task automatic t_reset;
    check({hiz, low, crow, pg, ovl, ref_lvl}, 13'h1000, "reset outputs");
    rd(8'h00, v);
    check(v, 32'h1, "ctrl reset");
    rd(8'h08, v);
    check(v, 32'h0, "unmapped read");
    wr(8'h04, 32'hffffffff);
    wr(8'h00, 32'h0);
    rd(8'h00, v);
    check(v, 32'h0, "ctrl write");
    wr(8'h00, 32'h1);
    rd(8'h04, v);
    check(v[2:0], 3'h0, "code all ones off");
    @(posedge mclk);
    ov_code <= 1'b1;
    tick(5);
    check(low, 1'b0, "code level ignored before enable");
    @(posedge mclk);
    ov17 <= 1'b1;
    tick(5);
    check({low, crow, ovl}, 4'he, "1v7 level before enable");
    @(posedge mclk);
    {ov_code, ov17, b06} <= 3'h1;
    llg <= 1'b0;
    tick(5);
    @(posedge mclk);
    {llg, b06} <= 2'h2;
    tick(5);
    rd(8'h04, v);
    check({v[5:4], v[2:0], ovl}, 7'h00, "gate cycle clears trip");
  endtask
  task automatic t_start;
    @(posedge mclk);
    code <= 6'h02;
    wait_st(3'h1, 4);
    @(posedge mclk);
    ov_code <= 1'b1;
    tick(5);
    check(low, 1'b0, "code level alone in soft-start");
    @(posedge mclk);
    ov_code <= 1'b0;
    tick(224);
    rd(8'h04, v);
    check(v[2:0], 3'h1, "delay too short");
    wait_st(3'h2, 20);
    check({hiz, ovl, ofs}, 7'h58, "ramp start");
    r0 = ref_lvl;
    tick(80);
    check(ref_lvl - r0 >= 9 && ref_lvl - r0 <= 11, 1'b1, "ramp rate");
    @(posedge mclk);
    pre <= 1'b1;
    tick(5);
    check(hiz, 1'b0, "prebias release");
    wait_st(3'h3, 300);
    check({ref_lvl, pg, ovl}, 10'h166, "run");
    tick(2600);
    check(ofs, 4'h0, "offset end");
  endtask
  task automatic t_uv_ov;
    @(posedge mclk);
    uv <= 1'b1;
    tick(5);
    check(pg, 1'b0, "uv");
    @(posedge mclk);
    uv <= 1'b0;
    ov_code <= 1'b1;
    tick(5);
    check({pg, low, crow, mode}, 5'h1e, "ov");
    @(posedge mclk);
    ov_code <= 1'b0;
    tick(10);
    check(low, 1'b1, "ov hold");
    @(posedge mclk);
    at_ref <= 1'b1;
    tick(5);
    check({low, hiz}, 2'h1, "at ref");
    @(posedge mclk);
    ov_code <= 1'b1;
    tick(5);
    check(low, 1'b1, "recur");
    @(posedge mclk);
    ov_code <= 1'b0;
    at_ref <= 1'b0;
    b06 <= 1'b1;
    tick(5);
    check(low, 1'b0, "below 0v6");
    @(posedge mclk);
    code <= 6'h3f;
    tick(20);
    @(posedge mclk);
    code <= 6'h02;
    tick(20);
    rd(8'h04, v);
    check({v[2:0], ovl}, 5'h1a, "ov latched");
    @(posedge mclk);
    b06 <= 1'b0;
    llg <= 1'b0;
    tick(10);
    check(pg, 1'b0, "disable");
    @(posedge mclk);
    llg <= 1'b1;
    wait_st(3'h1, 4);
  endtask
  task automatic t_noload;
    wait_st(3'h3, 400);
    @(posedge mclk);
    code <= 6'h3f;
    tick(5);
    check(hiz, 1'b0, "noload wait");
    tick(12);
    check({hiz, pg, ovl}, 4'h8, "noload off");
    @(posedge mclk);
    code <= 6'h02;
    wait_st(3'h1, 4);
    @(posedge mclk);
    code <= 6'h3f;
    tick(6);
    check(hiz, 1'b1, "noload from delay");
    @(posedge mclk);
    code <= 6'h02;
    wait_st(3'h1, 8);
  endtask
  task automatic t_oc;
    wait_st(3'h3, 400);
    @(posedge mclk);
    avg_oc <= 1'b1;
    tick(5);
    check({hiz, pg}, 2'h3, "avg oc");
    @(posedge mclk);
    avg_oc <= 1'b0;
    wait_st(3'h5, 2);
    tick(16300);
    wait_st(3'h1, 60);
    wait_st(3'h3, 400);
    @(posedge mclk);
    ph_oc <= 4'h4;
    tick(20);
    rd(8'h04, v);
    check(v[2:0], 3'h3, "phase oc early");
    wait_st(3'h5, 10);
    check({pg, hiz}, 2'h3, "phase oc keeps power-good");
    @(posedge mclk);
    ph_oc <= 4'h0;
    llg <= 1'b0;
    tick(16400);
    wait_st(3'h0, 20);
    check(pg, 1'b0, "gate drop clears power-good");
    @(posedge mclk);
    sv <= 1'b0;
    saux <= 1'b1;
    ov_aux <= 1'b1;
    tick(5);
    check(low, 1'b1, "aux ov");
    @(posedge mclk);
    ov_aux <= 1'b0;
    b15 <= 1'b1;
    tick(5);
    check({low, clash}, 2'h0, "aux release");
  endtask

  task automatic summarize;
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    {rst_n, wr_en, rd_en, addr, wdata, ov_aux, ov17, ov15, ov_code, b06, b15} = '0;
    {at_ref, uv, pre, avg_oc, ph_oc, failures, checks, cyc} = '0;
    {sv, saux, rail, llg, code} = {4'hf, 6'h3f};
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    tick(4);
    t_reset();
    t_start();
    t_uv_ov();
    t_noload();
    t_oc();
    summarize();
  end
endmodule
